// >>> logic/fpc_pkg.sv
`default_nettype none
package fpc_pkg;
    // register offsets on the bus
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_COND   = 8'h04;
    localparam logic [7:0] ADDR_DEST_LO = 8'h08;
    localparam logic [7:0] ADDR_DEST_HI = 8'h0C;
    localparam logic [7:0] ADDR_STATE  = 8'h10;
    // status register bit positions, vector index (field 0 sits at the top)
    localparam int BIT_EXC_SUM = 31;
    localparam int BIT_EN_SUM  = 30;
    localparam int BIT_INV_SUM = 29;
    localparam int BIT_OVF     = 28;
    localparam int BIT_UX     = 27;
    localparam int BIT_ZX     = 26;
    localparam int BIT_XX     = 25;
    localparam int BIT_SNAN   = 24;
    localparam int BIT_INV_CMP  = 19;
    localparam int BIT_CMP_CODE = 15;
    localparam int BIT_INV_EN   = 7;
    localparam int BIT_OE     = 6;
    localparam int BIT_UE     = 5;
    localparam int BIT_ZE     = 4;
    localparam int BIT_XE     = 3;
    // invalid-operation cause bits and all clearable exception bits
    localparam logic [31:0] INV_CAUSE_MASK = 32'h01F8_0700;
    localparam logic [31:0] EXC_MASK      = 32'h9FF8_0700;
    localparam logic [31:0] STATUS_RESET  = 32'h0000_0000;
    localparam logic [31:0] COND_RESET    = 32'h0000_0000;
    // one-hot compare outcome, field bit 0 in the top position
    localparam logic [3:0] REL_LT = 4'h8;
    localparam logic [3:0] REL_GT = 4'h4;
    localparam logic [3:0] REL_EQ = 4'h2;
    localparam logic [3:0] REL_UN = 4'h1;
    localparam logic [2:0] SUMMARY_FIELD = 3'h0;
    localparam logic [2:0] RECORD_FIELD  = 3'h1;

    typedef enum logic [2:0] {
        OP_CMPU,
        OP_CMPO,
        OP_MFFS,
        OP_MCRFS,
        OP_MTFSFI
    } fpc_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DRAIN,
        ST_EXEC,
        ST_DONE
    } fpc_state_t;
endpackage
`default_nettype wire

// >>> logic/fpc_core_if.sv
`default_nettype none
interface fpc_core_if;
    logic [63:0] src_a;
    logic [63:0] src_b;
    logic [3:0]  relation;
    logic        any_snan;
    logic        any_qnan;
    logic [31:0] old_status;
    logic [31:0] cand_status;
    logic        fx_direct;
    logic [31:0] new_status;

    modport top (output src_a, output src_b, input relation, input any_snan,
                 input any_qnan, output old_status, output cand_status,
                 output fx_direct, input new_status);
    modport cmp (input src_a, input src_b, output relation, output any_snan,
                 output any_qnan);
    modport summ (input old_status, input cand_status, input fx_direct,
                  output new_status);
endinterface
`default_nettype wire

// >>> logic/fpc_cmp_unit.sv
`default_nettype none
module fpc_cmp_unit #(
    parameter int EXP_W  = 11,
    parameter int FRAC_W = 52
) (
    fpc_core_if.cmp cif
);
    localparam int W = 1 + EXP_W + FRAC_W;

    if (W != 64) begin : g_width_check
        $error("fpc_cmp_unit serves 64-bit operands only");
    end

    function automatic logic is_nan(input logic [63:0] v);
        return (&v[62:52]) && (|v[51:0]);
    endfunction

    logic a_nan;
    logic b_nan;
    logic a_zero;
    logic b_zero;
    logic mag_gt;
    logic mag_eq;

    always_comb begin
        a_nan  = is_nan(cif.src_a);
        b_nan  = is_nan(cif.src_b);
        a_zero = ~|cif.src_a[62:0];
        b_zero = ~|cif.src_b[62:0];
        mag_gt = cif.src_a[62:0] > cif.src_b[62:0];
        mag_eq = cif.src_a[62:0] == cif.src_b[62:0];
        cif.any_snan = (a_nan && !cif.src_a[51]) || (b_nan && !cif.src_b[51]);
        cif.any_qnan = (a_nan && cif.src_a[51]) || (b_nan && cif.src_b[51]);
        if (a_nan || b_nan) begin
            cif.relation = fpc_pkg::REL_UN;
        end else if ((a_zero && b_zero) || (mag_eq && cif.src_a[63] == cif.src_b[63])) begin
            cif.relation = fpc_pkg::REL_EQ;
        end else if (cif.src_a[63] != cif.src_b[63]) begin
            cif.relation = cif.src_a[63] ? fpc_pkg::REL_LT : fpc_pkg::REL_GT;
        end else if (mag_gt ^ cif.src_a[63]) begin
            cif.relation = fpc_pkg::REL_GT;
        end else begin
            cif.relation = fpc_pkg::REL_LT;
        end
    end
endmodule
`default_nettype wire

// >>> logic/fpc_summary_unit.sv
`default_nettype none
module fpc_summary_unit (
    fpc_core_if.summ sif
);
    logic [31:0] s;
    logic        rise;

    always_comb begin
        s = sif.cand_status;
        s[fpc_pkg::BIT_INV_SUM] = |(s & fpc_pkg::INV_CAUSE_MASK);
        s[fpc_pkg::BIT_EN_SUM] = (s[fpc_pkg::BIT_INV_SUM] & s[fpc_pkg::BIT_INV_EN])
                            | (s[fpc_pkg::BIT_OVF] & s[fpc_pkg::BIT_OE])
                            | (s[fpc_pkg::BIT_UX] & s[fpc_pkg::BIT_UE])
                            | (s[fpc_pkg::BIT_ZX] & s[fpc_pkg::BIT_ZE])
                            | (s[fpc_pkg::BIT_XX] & s[fpc_pkg::BIT_XE]);
        rise = |(fpc_pkg::EXC_MASK & s & ~sif.old_status & 32'h7FFF_FFFF);
        // direct load of the summary bit overrides the rise rule
        if (!sif.fx_direct && rise) begin
            s[fpc_pkg::BIT_EXC_SUM] = 1'b1;
        end
        sif.new_status = s;
    end
endmodule
`default_nettype wire

// >>> logic/fpc_top.sv
// Notes on behaviour
// - both compares write the outcome to the chosen condition field and compare code
// - a NaN operand of either kind yields the unordered relation
// - any signalling NaN operand sets the signalling-NaN invalid flag
// - ordered compare with signalling NaN sets invalid-compare only when enable is zero
// - ordered compare with quiet NaN sets invalid-compare; unordered compare does not
// - status instructions wait until all earlier floating-point work has finished
// - earlier exceptions are recorded in the status register before it starts
// - pending exception-handler entries are taken before it starts
// - later status-dependent floating-point instructions are held until it completes
// - memory-access floating-point instructions are never held by this
// - move-from-status puts the status register in the low destination word
// - copy-status-field moves a 4-bit status field into a condition field
// - exception bits moved by copy-status-field are cleared in the status register
// - immediate write loads one status field and leaves the others unchanged except the summary bits of field zero
// - immediate write to field zero loads summary and overflow bits from immediate
// - for field zero the other two summary bits follow their normal rules
// - record forms of move-from-status and immediate write also update the condition register
// - positive and negative zero compare equal
// - a compare sets exactly one of less, greater, equal, unordered bits
// - the compare code gets the same one-hot pattern as the condition field
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`default_nettype none
module fpc_top (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire logic             instr_valid,
    input  wire fpc_pkg::fpc_op_t instr_op,
    input  wire logic             instr_record,
    input  wire logic [2:0]       dest_cond_field,
    input  wire logic [2:0]       source_status_field,
    input  wire logic [3:0]       field_immediate,
    input  wire logic [63:0]      fp_source_a,
    input  wire logic [63:0]      fp_source_b,
    input  wire logic             earlier_fp_idle,
    input  wire logic             handler_pending,
    input  wire logic             exc_valid,
    input  wire logic [31:0]      exc_bits,
    output logic                  instr_ready,
    output logic                  instr_done,
    output logic                  fp_arith_hold,
    output logic [63:0]           fp_dest,
    output logic                  fp_dest_we,
    output logic [31:0]           cond_reg,
    output logic [31:0]           fp_status_control_reg
);
    typedef struct packed {
        fpc_pkg::fpc_state_t state;
        fpc_pkg::fpc_op_t    op;
        logic                record;
        logic [2:0]          crf_d;
        logic [2:0]          crf_s;
        logic [3:0]          load_nib;
        logic [31:0]         status;
        logic [31:0]         cond;
        logic [63:0]         dest;
        logic                dest_we;
        logic                done;
        logic                ready;
        logic                hold;
        logic                wr_pend;
        logic [7:0]          wr_addr;
        logic [31:0]         rdata;
        logic                readyout;
    } fpc_regs_t;

    fpc_regs_t r;
    fpc_regs_t next_r;
    fpc_core_if core ();

    fpc_cmp_unit #(
        .EXP_W  (11),
        .FRAC_W (52)
    ) u_cmp (
        .cif (core.cmp)
    );

    fpc_summary_unit u_summary (
        .sif (core.summ)
    );

    function automatic logic [3:0] get_field(input logic [31:0] v, input logic [2:0] f);
        return v[31 - 4 * int'(f) -: 4];
    endfunction

    function automatic logic [31:0] set_field(input logic [31:0] v, input logic [2:0] f,
                                              input logic [3:0] n);
        logic [31:0] t;
        t = v;
        t[31 - 4 * int'(f) -: 4] = n;
        return t;
    endfunction

    function automatic logic [31:0] field_mask(input logic [2:0] f);
        return 32'hF000_0000 >> (4 * int'(f));
    endfunction

    logic [31:0] cand;
    logic        fx_direct;
    logic        status_upd;
    logic        accept;
    logic        is_status_op;
    logic [31:0] status_now;

    assign core.src_a       = fp_source_a;
    assign core.src_b       = fp_source_b;
    assign core.old_status  = r.status;
    assign core.cand_status = cand;
    assign core.fx_direct   = fx_direct;

    always_comb begin
        accept       = instr_valid && r.ready;
        is_status_op = (instr_op == fpc_pkg::OP_MFFS) || (instr_op == fpc_pkg::OP_MCRFS)
                    || (instr_op == fpc_pkg::OP_MTFSFI);
        cand       = r.status;
        fx_direct  = 1'b0;
        status_upd = 1'b0;
        if (accept && !is_status_op) begin
            // compare outcome into compare code
            cand[fpc_pkg::BIT_CMP_CODE -: 4] = core.relation;
            if (core.any_snan) begin
                cand[fpc_pkg::BIT_SNAN] = 1'b1;
            end
            if (instr_op == fpc_pkg::OP_CMPO) begin
                if (core.any_snan && !r.status[fpc_pkg::BIT_INV_EN]) begin
                    cand[fpc_pkg::BIT_INV_CMP] = 1'b1;
                end else if (!core.any_snan && core.any_qnan) begin
                    cand[fpc_pkg::BIT_INV_CMP] = 1'b1;
                end
            end
            status_upd = 1'b1;
        end else if (r.state == fpc_pkg::ST_EXEC) begin
            case (r.op)
                fpc_pkg::OP_MCRFS: begin
                    cand = r.status & ~(field_mask(r.crf_s) & fpc_pkg::EXC_MASK);
                    status_upd = 1'b1;
                end
                fpc_pkg::OP_MTFSFI: begin
                    cand = set_field(r.status, r.crf_d, r.load_nib);
                    fx_direct = (r.crf_d == fpc_pkg::SUMMARY_FIELD);
                    status_upd = 1'b1;
                end
                default: begin
                    status_upd = 1'b0;
                end
            endcase
        end
    end

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        next_r.dest_we = 1'b0;
        status_now = status_upd ? core.new_status : r.status;
        case (r.state)
            fpc_pkg::ST_IDLE: begin
                if (accept) begin
                    next_r.op = instr_op;
                    next_r.record = instr_record;
                    next_r.crf_d = dest_cond_field;
                    next_r.crf_s = source_status_field;
                    next_r.load_nib = field_immediate;
                    if (is_status_op) begin
                        next_r.state = fpc_pkg::ST_DRAIN;
                        next_r.ready = 1'b0;
                        next_r.hold = 1'b1;
                    end else begin
                        next_r.cond = set_field(r.cond, dest_cond_field,
                                                core.relation);
                        next_r.done = 1'b1;
                    end
                end
            end
            fpc_pkg::ST_DRAIN: begin
                // start only once earlier work, its exceptions and handlers are settled
                if (earlier_fp_idle && !exc_valid && !handler_pending) begin
                    next_r.state = fpc_pkg::ST_EXEC;
                end
            end
            fpc_pkg::ST_EXEC: begin
                case (r.op)
                    fpc_pkg::OP_MFFS: begin
                        next_r.dest = {32'h0000_0000, r.status};
                        next_r.dest_we = 1'b1;
                    end
                    fpc_pkg::OP_MCRFS: begin
                        next_r.cond = set_field(r.cond, r.crf_d,
                                                get_field(r.status, r.crf_s));
                    end
                    default: begin
                        next_r.dest = r.dest;
                    end
                endcase
                next_r.state = fpc_pkg::ST_DONE;
            end
            fpc_pkg::ST_DONE: begin
                if (r.record && r.op != fpc_pkg::OP_MCRFS) begin
                    next_r.cond = set_field(r.cond, fpc_pkg::RECORD_FIELD,
                                            get_field(r.status,
                                                      fpc_pkg::SUMMARY_FIELD));
                end
                next_r.done = 1'b1;
                next_r.hold = 1'b0;
                next_r.ready = 1'b1;
                next_r.state = fpc_pkg::ST_IDLE;
            end
            default: begin
                next_r.state = fpc_pkg::ST_IDLE;
                next_r.ready = 1'b1;
                next_r.hold = 1'b0;
            end
        endcase

        // bus slave: zero-wait, read data captured in the address phase
        next_r.readyout = 1'b1;
        if (r.wr_pend && r.wr_addr == fpc_pkg::ADDR_STATUS) begin
            status_now = hwdata;
        end
        next_r.wr_pend = 1'b0;
        if (hsel && hready && htrans[1]) begin
            next_r.wr_pend = hwrite;
            next_r.wr_addr = haddr[7:0];
            case (haddr[7:0])
                fpc_pkg::ADDR_STATUS: next_r.rdata = r.status;
                fpc_pkg::ADDR_COND: next_r.rdata = r.cond;
                fpc_pkg::ADDR_DEST_LO: next_r.rdata = r.dest[31:0];
                fpc_pkg::ADDR_DEST_HI: next_r.rdata = r.dest[63:32];
                fpc_pkg::ADDR_STATE: next_r.rdata = {29'h0, r.hold, !r.ready,
                                                    r.state == fpc_pkg::ST_DRAIN};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end

        // exceptions from earlier instructions land on top; a set beats any clear
        if (exc_valid) begin
            // rise test looks at the bits before they are merged
            if (|(exc_bits & fpc_pkg::EXC_MASK & ~status_now)) begin
                status_now[fpc_pkg::BIT_EXC_SUM] = 1'b1;
            end
            status_now = status_now | exc_bits;
        end
        next_r.status = status_now;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            r <= '{state: fpc_pkg::ST_IDLE, op: fpc_pkg::OP_CMPU,
                   status: fpc_pkg::STATUS_RESET, cond: fpc_pkg::COND_RESET,
                   ready: 1'b1, readyout: 1'b1, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // memory-access instructions bypass this block, so nothing here stalls them
    assign hrdata                = r.rdata;
    assign hreadyout             = r.readyout;
    assign hresp                 = 1'b0;
    assign instr_ready           = r.ready;
    assign instr_done            = r.done;
    assign fp_arith_hold         = r.hold;
    assign fp_dest               = r.dest;
    assign fp_dest_we            = r.dest_we;
    assign cond_reg              = r.cond;
    assign fp_status_control_reg = r.status;
endmodule
`default_nettype wire

// >>> testbench/fpc_seq_model.sv
`default_nettype none
// earlier floating-point work and handler entries seen by the sequencer:
// busy for len cycles, then a handler entry outstanding for len cycles
module fpc_seq_model #(
    parameter logic [31:0] EXC = 32'h0400_0000
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [7:0]  len,
    output logic             earlier_fp_idle,
    output logic             handler_pending,
    output logic             exc_valid,
    output logic [31:0]      exc_bits
);
    logic [7:0] busy;
    logic [7:0] hand;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy <= 8'h00;
            hand <= 8'h00;
        end else if (start) begin
            busy <= len;
            hand <= len;
        end else if (busy != 8'h00) begin
            busy <= busy - 8'h01;
        end else if (hand != 8'h00) begin
            hand <= hand - 8'h01;
        end
    end
    assign earlier_fp_idle = (busy == 8'h00);
    assign handler_pending = (busy == 8'h00) && (hand != 8'h00);
    // last busy cycle reports an exception; otherwise the bits are junk
    assign exc_valid = (busy == 8'h01);
    assign exc_bits = exc_valid ? EXC : ~EXC;
endmodule
`default_nettype wire

// >>> testbench/fpc_top_assertions.sv
`default_nettype none
module fpc_top_assertions (
    input wire logic             clock,
    input wire logic             rst,
    input wire logic             instr_valid,
    input wire fpc_pkg::fpc_op_t instr_op,
    input wire logic             instr_ready,
    input wire logic             instr_done,
    input wire logic             fp_arith_hold,
    input wire logic [2:0]       dest_cond_field,
    input wire logic [63:0]      fp_source_a,
    input wire logic [63:0]      fp_source_b,
    input wire logic             earlier_fp_idle,
    input wire logic             handler_pending,
    input wire logic             exc_valid,
    input wire logic [63:0]      fp_dest,
    input wire logic             fp_dest_we,
    input wire logic [31:0]      cond_reg,
    input wire logic [31:0]      fp_status_control_reg
);
    logic       is_c;
    logic       cmp;
    logic       sop;
    logic       nan_in;
    logic       snan_in;
    logic [2:0] fld_q;
    logic [3:0] cmp_code;
    function automatic logic is_nan(input logic [63:0] x);
        return &x[62:52] && |x[51:0];
    endfunction
    assign is_c = (instr_op == fpc_pkg::OP_CMPU) || (instr_op == fpc_pkg::OP_CMPO);
    assign cmp = instr_valid && instr_ready && is_c;
    assign sop = instr_valid && instr_ready && !is_c;
    assign nan_in = is_nan(fp_source_a) || is_nan(fp_source_b);
    assign snan_in = (is_nan(fp_source_a) && !fp_source_a[51]) ||
                     (is_nan(fp_source_b) && !fp_source_b[51]);
    assign cmp_code = fp_status_control_reg[15:12];
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            fld_q <= 3'h0;
        end else begin
            fld_q <= dest_cond_field;
        end
    end
    default clocking dcb @(posedge clock); endclocking
    default disable iff (rst);
    AST_CMP_DONE: assert property (cmp |=> instr_done)
        else $error("compare did not complete");
    AST_CC_MATCH: assert property (cmp && !exc_valid |=> $onehot(cmp_code) &&
        cond_reg[31 - 4 * fld_q -: 4] == cmp_code) else $error("compare code mismatch");
    AST_NAN_UNORD: assert property (cmp && nan_in |=> cmp_code == fpc_pkg::REL_UN)
        else $error("nan not unordered");
    AST_SNAN: assert property (cmp && snan_in |=> fp_status_control_reg[fpc_pkg::BIT_SNAN])
        else $error("signalling flag not set");
    AST_INVCMP_SNAN: assert property (cmp && instr_op == fpc_pkg::OP_CMPO && snan_in &&
        !fp_status_control_reg[fpc_pkg::BIT_INV_EN] |=>
        fp_status_control_reg[fpc_pkg::BIT_INV_CMP])
        else $error("invalid compare flag missing");
    AST_INVCMP_QNAN: assert property (cmp && instr_op == fpc_pkg::OP_CMPO && nan_in &&
        !snan_in |=> fp_status_control_reg[fpc_pkg::BIT_INV_CMP]) else $error("quiet nan flag");
    AST_HOLD: assert property (sop |=> !instr_ready && fp_arith_hold)
        else $error("later work not held");
    AST_DRAIN: assert property (fp_arith_hold && (!earlier_fp_idle || handler_pending)
        |=> !instr_done && !fp_dest_we) else $error("started before drain");
    AST_DONE_BOUND: assert property (sop |-> ##[1:60] instr_done)
        else $error("status instruction stuck");
    AST_MFFS: assert property (fp_dest_we |->
        fp_dest == {32'h0000_0000, fp_status_control_reg}) else $error("move from status wrong");
    cover property (cmp ##1 cmp_code == fpc_pkg::REL_UN);
    cover property (sop ##[1:60] fp_dest_we);
    cover property (sop && instr_op == fpc_pkg::OP_MTFSFI ##[1:60] instr_done);
endmodule
bind fpc_top fpc_top_assertions chk_u (.clock, .rst, .instr_valid, .instr_op, .instr_ready,
    .instr_done, .fp_arith_hold, .dest_cond_field, .fp_source_a, .fp_source_b,
    .earlier_fp_idle, .handler_pending, .exc_valid, .fp_dest, .fp_dest_we, .cond_reg,
    .fp_status_control_reg);
`default_nettype wire

// >>> testbench/fp_compare_status_ctrl_bench.sv
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module fp_compare_status_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [63:0] ONE = 64'h3FF0_0000_0000_0000;
    localparam logic [63:0] TWO = 64'h4000_0000_0000_0000;
    localparam logic [63:0] NZ = 64'h8000_0000_0000_0000;
    localparam logic [63:0] QN = 64'h7FF8_0000_0000_0000;
    localparam logic [63:0] SN = 64'h7FF0_0000_0000_0001;
    localparam logic [63:0] TA [8] = '{ONE, TWO, 64'h0, QN, ONE, SN, SN, ONE};
    localparam logic [63:0] TB [8] = '{TWO, ONE, NZ, ONE, QN, ONE, ONE, SN};
    localparam logic [3:0] TR [8] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
    // per case: ordered, enable, signalling flag, invalid-compare flag
    localparam logic [3:0] TF [8] = '{4'h0, 4'h8, 4'h0, 4'h0, 4'h9, 4'hB, 4'hE, 4'h2};
    logic clock, rst, hsel, hwrite, hreadyout, hresp, instr_valid, instr_record;
    logic instr_ready, instr_done, fp_arith_hold, fp_dest_we, start;
    logic earlier_fp_idle, handler_pending, exc_valid;
    logic [1:0] htrans;
    logic [2:0] hsize, dest_cond_field, source_status_field;
    logic [3:0] field_immediate;
    logic [7:0] len;
    logic [31:0] haddr, hwdata, hrdata, exc_bits, cond_reg, fp_status_control_reg, q;
    logic [63:0] fp_source_a, fp_source_b, fp_dest;
    fpc_pkg::fpc_op_t instr_op;
    int n_fail, comparisons, cyc, n;
    fpc_top dut_u (.clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .instr_valid, .instr_op,
        .instr_record, .dest_cond_field, .source_status_field, .field_immediate,
        .fp_source_a, .fp_source_b, .earlier_fp_idle, .handler_pending, .exc_valid,
        .exc_bits, .instr_ready, .instr_done, .fp_arith_hold, .fp_dest, .fp_dest_we,
        .cond_reg, .fp_status_control_reg);
    fpc_seq_model seq_u (.clock, .rst, .start, .len, .earlier_fp_idle, .handler_pending,
        .exc_valid, .exc_bits);
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic issue(input fpc_pkg::fpc_op_t op, input logic rec, input logic [2:0] f,
        input logic [2:0] s, input logic [3:0] fi, input logic [63:0] a, input logic [63:0] b);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_record <= rec;
        dest_cond_field <= f;
        source_status_field <= s;
        field_immediate <= fi;
        fp_source_a <= a;
        fp_source_b <= b;
        do @(posedge clock); while (instr_ready !== 1'b1);
        instr_valid <= 1'b0;
        n = 0;
        #1;
        while (instr_done !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    task automatic t_reset();
        `CHK(fp_status_control_reg, 32'h0000_0000)
        `CHK({instr_ready, hreadyout, hresp, cond_reg}, {3'h6, 32'h0000_0000})
        bus(1'b1, fpc_pkg::ADDR_COND, 32'hFFFF_FFFF);
        bus(1'b0, fpc_pkg::ADDR_COND, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
        bus(1'b0, 8'h20, 32'h0000_0000);
        `CHK(q, 32'h0000_0000)
    endtask
    task automatic t_cmp();
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, fpc_pkg::ADDR_STATUS, TF[i][2] ? 32'h0000_0080 : 32'h0000_0000);
            issue(TF[i][3] ? fpc_pkg::OP_CMPO : fpc_pkg::OP_CMPU, 1'b0, i[2:0], 3'h0, 4'h0,
                TA[i], TB[i]);
            `CHK(cond_reg[31 - 4 * i -: 4], TR[i])
            `CHK(fp_status_control_reg[15:12], TR[i])
            `CHK(fp_status_control_reg[24], TF[i][1])
            `CHK(fp_status_control_reg[19], TF[i][0])
        end
    endtask
    task automatic t_mffs();
        bus(1'b1, fpc_pkg::ADDR_STATUS, 32'h5000_00F8);
        start <= 1'b1;
        len <= 8'h04;
        @(posedge clock);
        start <= 1'b0;
        issue(fpc_pkg::OP_MFFS, 1'b1, 3'h0, 3'h0, 4'h0, 64'h0, 64'h0);
        `CHK(fp_dest, 64'h0000_0000_D400_00F8)
        `CHK(n >= 8, 1'b1)
        `CHK(cond_reg[27:24], 4'hD)
        bus(1'b0, fpc_pkg::ADDR_DEST_LO, 32'h0000_0000);
        `CHK(q, 32'hD400_00F8)
    endtask
    task automatic t_fields();
        bus(1'b1, fpc_pkg::ADDR_STATUS, 32'h2000_0700);
        issue(fpc_pkg::OP_MCRFS, 1'b0, 3'h3, 3'h5, 4'h0, 64'h0, 64'h0);
        `CHK(cond_reg[19:16], 4'h7)
        `CHK(fp_status_control_reg, 32'h0000_0000)
        issue(fpc_pkg::OP_MTFSFI, 1'b0, 3'h6, 3'h0, 4'hA, 64'h0, 64'h0);
        `CHK(fp_status_control_reg, 32'h0000_00A0)
        issue(fpc_pkg::OP_MTFSFI, 1'b1, 3'h0, 3'h0, 4'h7, 64'h0, 64'h0);
        `CHK(fp_status_control_reg, 32'h1000_00A0)
        `CHK(cond_reg[27:24], 4'h1)
        bus(1'b0, fpc_pkg::ADDR_STATUS, 32'h0000_0000);
        `CHK(q, 32'h1000_00A0)
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end
    initial begin
        {rst, hsel, hwrite, htrans, hwdata, haddr, start, len} = {1'b1, 77'h0};
        hsize = 3'h2;
        {instr_valid, instr_record, dest_cond_field, source_status_field} = 8'h00;
        {field_immediate, fp_source_a, fp_source_b} = 132'h0;
        instr_op = fpc_pkg::OP_CMPU;
        {n_fail, comparisons, cyc} = 96'h0;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_reset();
        t_cmp();
        t_mffs();
        t_fields();
        end_of_test();
    end
endmodule
`default_nettype wire
